// ### io_port_consts.svh
// Constants of the bytewise I/O port: register offsets, reset values and
// field positions of the per-line configuration.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

// Data-space offsets of the three port registers, relative to the port base
`define PORT_DATA_OFF 8'h00
`define PORT_DIR_OFF 8'h01
`define PORT_OPT_OFF 8'h02

// Every port register clears to zero
`define PORT_REG_RESET 8'h00

// Width of a port and of the data-space address
`define PORT_WIDTH 8
`define DSPACE_AW 8

// Bit positions inside the packed line configuration {dir, opt, data}
`define CFG_DIR_BIT 2
`define CFG_OPT_BIT 1
`define CFG_DATA_BIT 0

// Interrupt trigger codes chosen per port by the interrupt controller
`define TRIG_FALLING 2'h0
`define TRIG_RISING 2'h1
`define TRIG_LOW 2'h2

`endif

// ### io_port_pkg.sv
// Types shared by the I/O port modules.
// Assumes io_port_consts.svh is on the include path.
`include "io_port_consts.svh"

package io_port_pkg;

    // Configuration bits of one line, in the order direction, option, data
    typedef struct packed {
        logic dir;
        logic opt;
        logic data;
    } line_cfg_t;

    // Electrical mode that a line's three bits select
    typedef enum logic [2:0] {
        MODE_IN_PULLUP = 3'b000,
        MODE_IN_HIZ = 3'b001,
        MODE_IN_PULLUP_INT = 3'b010,
        MODE_IN_ANALOG = 3'b011,
        MODE_OUT_OPEN_DRAIN = 3'b100,
        MODE_OUT_PUSH_PULL = 3'b101
    } line_mode_t;

    // What a line presents at its pad
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic analog_sel;
        logic int_en;
    } line_drive_t;

    // Trigger kind for the lines routed to the interrupt system
    typedef enum logic [1:0] {
        TRIG_FALL = 2'b00,
        TRIG_RISE = 2'b01,
        TRIG_LEVEL_LOW = 2'b10
    } trig_t;

endpackage

// ### pin_sync.sv
// Three-stage synchroniser for one pad input with agreement filter.
// Assumes the pad is asynchronous to clk; the filtered level changes only
// once the second and third stages agree.
`timescale 1ns/100ps

module pin_sync
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pad,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    always_comb
    begin
        level_next = level_reg;
        if (s2_reg == s3_reg)
        begin
            level_next = s3_reg;
        end
    end

    // Pads idle high under the reset pull-ups, so start the chain high
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= pad;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

// ### line_cell.sv
// Mode decode and pad drive of one port line.
// Assumes its configuration comes straight from the port registers.
`timescale 1ns/100ps

module line_cell
    import io_port_pkg::*;
#(
    parameter bit ANALOG_CAPABLE = 1'b1
)
(
    input line_cfg_t cfg,
    output line_mode_t mode,
    output line_drive_t drive
);
    always_comb
    begin
        case ({cfg.dir, cfg.opt, cfg.data})
            3'b000: mode = MODE_IN_PULLUP;
            3'b001: mode = MODE_IN_HIZ;
            3'b010: mode = MODE_IN_PULLUP_INT;
            3'b011: mode = MODE_IN_ANALOG;
            3'b100: mode = MODE_OUT_OPEN_DRAIN;
            3'b101: mode = MODE_OUT_OPEN_DRAIN;
            default: mode = MODE_OUT_PUSH_PULL;
        endcase
    end

    always_comb
    begin
        drive = '0;
        case (mode)
            MODE_IN_PULLUP:
            begin
                drive.pull_up = 1'b1;
            end
            MODE_IN_HIZ:
            begin
                drive.pull_up = 1'b0;
            end
            MODE_IN_PULLUP_INT:
            begin
                drive.pull_up = 1'b1;
                drive.int_en = 1'b1;
            end
            MODE_IN_ANALOG:
            begin
                // A line without a converter input is left floating
                drive.analog_sel = ANALOG_CAPABLE;
            end
            MODE_OUT_OPEN_DRAIN:
            begin
                drive.out = 1'b0;
                drive.oe = ~cfg.data;
            end
            MODE_OUT_PUSH_PULL:
            begin
                drive.out = cfg.data;
                drive.oe = 1'b1;
            end
            default:
            begin
                drive = '0;
            end
        endcase
    end
endmodule

// ### io_port.sv
// Bytewise general-purpose I/O port: data, direction and option registers
// in data space, per-line mode decode, pad drive and interrupt request.
// Assumes the core issues single-cycle read and write strobes and that the
// pad wire, pull-up resistors and analog switch sit outside this module.
`timescale 1ns/100ps
`include "io_port_consts.svh"

module io_port
    import io_port_pkg::*;
#(
    parameter int WIDTH = `PORT_WIDTH,
    parameter logic [`DSPACE_AW-1:0] BASE = 8'hc0,
    parameter logic [`PORT_WIDTH-1:0] ANALOG_MASK = 8'hff
)
(
    input wire logic clk,
    input wire logic nrst,
    // Data-space access from the core
    input wire logic [`DSPACE_AW-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata,
    output logic rd_valid,
    output logic sel,
    // Trigger selection held in the interrupt option register
    input wire logic [1:0] int_trig,
    output logic irq_req,
    // Pads
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pull_up_en,
    output logic [WIDTH-1:0] analog_sel
);
    // Each configuration register is one byte, so a port cannot be wider
    if (WIDTH < 1 || WIDTH > `PORT_WIDTH)
    begin : g_bad_width
        $error("io_port: WIDTH must lie between 1 and the port width");
    end

    localparam logic [`DSPACE_AW-1:0] DATA_ADDR = BASE + `PORT_DATA_OFF;
    localparam logic [`DSPACE_AW-1:0] DIR_ADDR = BASE + `PORT_DIR_OFF;
    localparam logic [`DSPACE_AW-1:0] OPT_ADDR = BASE + `PORT_OPT_OFF;

    // Access state: a read returns its word one cycle after the strobe
    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_READ = 1'b1
    } acc_state_t;

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] opt_reg;
    logic [WIDTH-1:0] opt_next;

    logic hit_data;
    logic hit_dir;
    logic hit_opt;

    always_comb
    begin
        hit_data = (addr == DATA_ADDR);
        hit_dir = (addr == DIR_ADDR);
        hit_opt = (addr == OPT_ADDR);
    end

    always_comb
    begin
        data_next = data_reg;
        dir_next = dir_reg;
        opt_next = opt_reg;
        if (wr_en)
        begin
            // Data writes always reach the latch, even on input lines,
            // because the latch selects the input characteristics.
            if (hit_data)
            begin
                data_next = wdata;
            end
            if (hit_dir)
            begin
                dir_next = wdata;
            end
            if (hit_opt)
            begin
                opt_next = wdata;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            data_reg <= `PORT_REG_RESET;
            dir_reg <= `PORT_REG_RESET;
            opt_reg <= `PORT_REG_RESET;
        end
        else
        begin
            data_reg <= data_next;
            dir_reg <= dir_next;
            opt_reg <= opt_next;
        end
    end

    // ---------------------------------------------------------------
    // Per-line decode and pad synchronisers
    // ---------------------------------------------------------------
    line_drive_t drive [WIDTH];
    logic [WIDTH-1:0] pin_level;
    logic [WIDTH-1:0] int_en_vec;
    logic [WIDTH-1:0] pull_vec;
    logic [WIDTH-1:0] analog_vec;
    logic [WIDTH-1:0] out_vec;
    logic [WIDTH-1:0] oe_vec;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1)
        begin : g_line
            line_cfg_t cfg;

            assign cfg = '{dir: dir_reg[gi], opt: opt_reg[gi], data: data_reg[gi]};

            line_cell #(
                .ANALOG_CAPABLE(ANALOG_MASK[gi])
            ) u_cell (
                .cfg(cfg),
                .mode(),
                .drive(drive[gi])
            );

            pin_sync u_sync (
                .clk(clk),
                .nrst(nrst),
                .pad(pin_in[gi]),
                .level(pin_level[gi])
            );

            assign out_vec[gi] = drive[gi].out;
            assign oe_vec[gi] = drive[gi].oe;
            assign pull_vec[gi] = drive[gi].pull_up;
            assign analog_vec[gi] = drive[gi].analog_sel;
            // Output lines are cut off from the interrupt path
            assign int_en_vec[gi] = drive[gi].int_en & ~dir_reg[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    acc_state_t acc_reg;
    acc_state_t acc_next;
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;
    logic sel_reg;
    logic sel_next;

    always_comb
    begin
        acc_next = ACC_IDLE;
        rdata_next = rdata_reg;
        sel_next = 1'b0;
        case (acc_reg)
            ACC_IDLE,
            ACC_READ:
            begin
                if (rd_en && (hit_data || hit_dir || hit_opt))
                begin
                    acc_next = ACC_READ;
                    sel_next = 1'b1;
                    if (hit_data)
                    begin
                        // Inputs show the pad, outputs the latch
                        rdata_next = (pin_level & ~dir_reg) | (data_reg & dir_reg);
                    end
                    else if (hit_dir)
                    begin
                        rdata_next = dir_reg;
                    end
                    else
                    begin
                        rdata_next = opt_reg;
                    end
                end
                else if (rd_en)
                begin
                    // Not ours: answer zero so a wired-OR data bus stays clean
                    rdata_next = '0;
                end
            end
            default:
            begin
                acc_next = ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            acc_reg <= ACC_IDLE;
            rdata_reg <= '0;
            sel_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            rdata_reg <= rdata_next;
            sel_reg <= sel_next;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt request
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] level_prev_reg;
    logic [WIDTH-1:0] level_prev_next;
    logic irq_reg;
    logic irq_next;
    logic [WIDTH-1:0] fire;

    always_comb
    begin
        level_prev_next = pin_level;
        case (trig_t'(int_trig))
            TRIG_FALL: fire = level_prev_reg & ~pin_level;
            TRIG_RISE: fire = ~level_prev_reg & pin_level;
            TRIG_LEVEL_LOW: fire = ~pin_level;
            default: fire = '0;
        endcase
        // Edges are one-cycle pulses; the low level holds the request
        irq_next = |(fire & int_en_vec);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            level_prev_reg <= '1;
            irq_reg <= 1'b0;
        end
        else
        begin
            level_prev_reg <= level_prev_next;
            irq_reg <= irq_next;
        end
    end

    // ---------------------------------------------------------------
    // Pad drive, registered so that every pad output leaves a flop
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] pin_out_reg;
    logic [WIDTH-1:0] pin_oe_reg;
    logic [WIDTH-1:0] pull_reg;
    logic [WIDTH-1:0] analog_reg;

    // Register outputs lag the configuration by one cycle; in return no
    // glitch from the mode decode reaches a pad.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            pull_reg <= '1;
            analog_reg <= '0;
        end
        else
        begin
            pin_out_reg <= out_vec;
            pin_oe_reg <= oe_vec;
            pull_reg <= pull_vec;
            // Several set bits short pads together; software must prevent it
            analog_reg <= analog_vec;
        end
    end

    assign rdata = rdata_reg;
    assign rd_valid = (acc_reg == ACC_READ);
    assign sel = sel_reg;
    assign irq_req = irq_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign pull_up_en = pull_reg;
    assign analog_sel = analog_reg;
endmodule

// ### io_port_chk.sv
// Port-level assertions for the bytewise I/O port.
// Assumes it is bound into every io_port instance.
`timescale 1ns/100ps

module io_port_chk
#(
    parameter logic [7:0] BASE = 8'hc0,
    parameter logic [7:0] ANALOG_MASK = 8'hff
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rd_valid,
    input wire logic sel,
    input wire logic irq_req,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] analog_sel
);
    logic hit;
    assign hit = addr >= BASE && addr <= BASE + 8'h02;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_reset_pads: assert property ($rose(nrst) |-> pin_oe == 8'h00 &&
        pull_up_en == 8'hff && analog_sel == 8'h00 && !irq_req)
        else $error("pads not at reset state");
    a_read_answer: assert property (rd_en && hit |=> rd_valid && sel)
        else $error("mapped read not answered");
    a_unmapped_read: assert property (rd_en && !hit |=> !rd_valid && rdata == 8'h00)
        else $error("unmapped read answered");
    a_valid_cause: assert property (rd_valid |-> $past(rd_en) && $past(hit))
        else $error("read valid without read");
    a_dir_gates_oe: assert property (wr_en && addr == BASE + 8'h01 ##1 !wr_en
        |=> (pin_oe & ~$past(wdata, 2)) == 8'h00)
        else $error("input line driven");
    a_no_pull_out: assert property ((pull_up_en & pin_oe) == 8'h00)
        else $error("pull-up on driven line");
    a_analog_clean: assert property ((analog_sel & (pin_oe | pull_up_en | ~ANALOG_MASK))
        == 8'h00)
        else $error("analog select on wrong line");
    a_out_needs_oe: assert property ((pin_out & ~pin_oe) == 8'h00)
        else $error("output high while undriven");
    a_irq_input_only: assert property (irq_req |->
        pull_up_en != 8'h00 || $past(pull_up_en) != 8'h00)
        else $error("request with no interrupt input");

    c_read: cover property (rd_en && hit ##1 rd_valid);
    c_irq: cover property ($rose(irq_req));
    c_push_pull: cover property (pin_oe == 8'hff && pin_out != 8'h00);
endmodule

bind io_port io_port_chk #(.BASE(BASE), .ANALOG_MASK(ANALOG_MASK)) chk_u (.clk(clk),
    .nrst(nrst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .sel(sel), .irq_req(irq_req),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .analog_sel(analog_sel));

// ### pad_model.sv
// Pads and outside devices: resolves each pad from port drive, an outside
// driver, the pull-up, or a floating level that changes every cycle.
`timescale 1ns/100ps

module pad_model
(
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad
);
    // A floating pad must not settle to a friendly constant
    logic [7:0] float_reg = 8'h55;
    always @(posedge clk) float_reg <= ~float_reg;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i]) pad[i] = pin_out[i];
            else if (ext_oe[i]) pad[i] = ext_val[i];
            else if (pull_up_en[i]) pad[i] = 1'b1;
            else pad[i] = float_reg[i];
        end
    end
endmodule

// ### tb_top.sv
// Self-checking bench for io_port with a pad model on the far side.
// Assumes the default port base c0 and offsets 0, 1, 2.
`timescale 1ns/100ps

module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [1:0] int_trig = 2'h3;
    logic [7:0] ext_oe = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] pad, rdata, pin_out, pin_oe, pull_up_en, analog_sel, q, f;
    logic rd_valid, sel, irq_req;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int c;

    always #5 clk = ~clk;

    io_port dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .sel(sel),
        .int_trig(int_trig), .irq_req(irq_req), .pin_in(pad), .pin_out(pin_out),
        .pin_oe(pin_oe), .pull_up_en(pull_up_en), .analog_sel(analog_sel));
    pad_model pad_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .ext_oe(ext_oe), .ext_val(ext_val), .pad(pad));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        @(negedge clk);
        addr = 8'hc0 + off;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    // Leaves data in q and {rd_valid, sel} in f; the flags stand for only
    // one cycle after the strobe edge, so the answer is taken there
    task automatic rd(input logic [7:0] off);
        @(negedge clk);
        addr = 8'hc0 + off;
        rd_en = 1'b1;
        @(negedge clk);
        q = rdata;
        f = {6'h00, rd_valid, sel};
        rd_en = 1'b0;
    endtask

    task automatic cnt_irq(input int n);
        c = 0;
        repeat (n)
        begin
            @(negedge clk);
            if (irq_req === 1'b1) c++;
        end
    endtask

    initial
    begin
        idle(3);
        nrst = 1'b1;
        idle(6);
        chk("pull_up_en", 8'hff, pull_up_en);
        chk("pin_oe", 8'h00, pin_oe);
        rd(1);
        chk("direction", 8'h00, q);
        rd(2);
        chk("option", 8'h00, q);
        rd(0);
        chk("data", 8'hff, q);
        chk("flags", 8'h03, f);
        $display("test reset done");

        ext_oe = 8'hff;
        ext_val = 8'ha5;
        wr(0, 8'h5a);
        idle(6);
        rd(0);
        chk("input data", 8'ha5, q);
        chk("pull_up_en", 8'ha5, pull_up_en);
        wr(1, 8'hff);
        wr(3, 8'h00);
        idle(2);
        chk("open drain oe", 8'ha5, pin_oe);
        chk("open drain out", 8'h00, pin_out);
        rd(0);
        chk("output data", 8'h5a, q);
        rd(1);
        chk("direction", 8'hff, q);
        rd(3);
        chk("unmapped data", 8'h00, q);
        chk("unmapped flags", 8'h00, f);
        wr(2, 8'hff);
        idle(2);
        chk("push pull oe", 8'hff, pin_oe);
        chk("push pull out", 8'h5a, pin_out);
        ext_oe = 8'h00;
        $display("test data done");

        // Line n takes configuration bits n: 000 001 010 011 100 101 110 111
        wr(0, 8'haa);
        wr(2, 8'hcc);
        wr(1, 8'hf0);
        idle(2);
        chk("mode pull_up_en", 8'h05, pull_up_en);
        chk("mode analog_sel", 8'h08, analog_sel);
        chk("mode pin_oe", 8'hd0, pin_oe);
        chk("mode pin_out", 8'h80, pin_out);
        $display("test modes done");

        wr(1, 8'h00);
        wr(2, 8'h01);
        wr(0, 8'h00);
        ext_oe = 8'h01;
        ext_val = 8'h01;
        int_trig = 2'h0;
        idle(8);
        cnt_irq(8);
        chk("steady high", 8'h00, c[7:0]);
        ext_val = 8'h00;
        cnt_irq(10);
        chk("falling", 8'h01, c[7:0]);
        int_trig = 2'h1;
        ext_val = 8'h01;
        cnt_irq(10);
        chk("rising", 8'h01, c[7:0]);
        int_trig = 2'h2;
        ext_val = 8'h00;
        idle(6);
        cnt_irq(8);
        chk("low level", 8'h08, c[7:0]);
        int_trig = 2'h3;
        cnt_irq(8);
        chk("no trigger", 8'h00, c[7:0]);
        int_trig = 2'h2;
        wr(1, 8'h01);
        idle(6);
        cnt_irq(8);
        chk("output line", 8'h00, c[7:0]);
        $display("test interrupt done");
        results();
    end
endmodule
